// ---- rtl/bcca_pkg.sv ----
// package of offsets, field positions, limits and timing for the bcd calendar block
package bcca_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ        = 25000000;
    // the divider phase counter steps at twice its fastest tap (64 Hz)
    localparam int unsigned PHASE_TICK_HZ     = 128;
    // whole cycles per phase step, rounded down
    localparam int unsigned PHASE_TICK_CYCLES = SYS_CLK_HZ / PHASE_TICK_HZ;

    // ------------------------------------------------------------------
    // register offsets on the 8-bit register port
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DIVIDER_PHASE  = 8'h00;
    localparam logic [7:0] OFS_SECONDS_COUNT  = 8'h02;
    localparam logic [7:0] OFS_MINUTES_COUNT  = 8'h04;
    localparam logic [7:0] OFS_HOURS_COUNT    = 8'h06;
    localparam logic [7:0] OFS_WEEKDAY_COUNT  = 8'h08;
    localparam logic [7:0] OFS_DATE_COUNT     = 8'h0A;
    localparam logic [7:0] OFS_MONTH_COUNT    = 8'h0C;
    localparam logic [7:0] OFS_YEAR_COUNT     = 8'h0E;
    localparam logic [7:0] OFS_SECONDS_ALARM  = 8'h10;
    localparam logic [7:0] OFS_MINUTES_ALARM  = 8'h12;
    localparam logic [7:0] OFS_HOURS_ALARM    = 8'h14;
    localparam logic [7:0] OFS_CONTROL_FIRST  = 8'h1C;
    localparam logic [7:0] OFS_CONTROL_SECOND = 8'h1E;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CARRY_FLAG_BIT    = 7;
    localparam int unsigned ALARM_FLAG_BIT    = 0;
    localparam int unsigned RUN_BIT           = 3;
    localparam int unsigned ADJUST_BIT        = 2;
    localparam int unsigned COUNTER_RESET_BIT = 1;
    localparam int unsigned ENABLE_BIT        = 7;
    localparam logic        RUN_RESET         = 1'b1;
    localparam logic        ENABLE_RESET      = 1'b0;

    // ------------------------------------------------------------------
    // writable bits of each location
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_SECONDS       = 8'h7F;
    localparam logic [7:0] MASK_MINUTES       = 8'h7F;
    localparam logic [7:0] MASK_HOURS         = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAY       = 8'h07;
    localparam logic [7:0] MASK_DATE          = 8'h3F;
    localparam logic [7:0] MASK_MONTH         = 8'h1F;
    localparam logic [7:0] MASK_YEAR          = 8'hFF;

    // ------------------------------------------------------------------
    // counting limits (bcd)
    // ------------------------------------------------------------------
    localparam logic [7:0] BCD_ZERO           = 8'h00;
    localparam logic [7:0] SIXTY_MAX          = 8'h59;
    localparam logic [7:0] HOURS_MAX          = 8'h23;
    localparam logic [7:0] WEEKDAY_MAX        = 8'h06;
    localparam logic [7:0] DATE_MIN           = 8'h01;
    localparam logic [7:0] MONTH_MIN          = 8'h01;
    localparam logic [7:0] MONTH_MAX          = 8'h12;
    localparam logic [7:0] YEAR_MAX           = 8'h99;
    localparam logic [7:0] ADJUST_ROUND_UP    = 8'h30;
    localparam logic [7:0] DAYS_28            = 8'h28;
    localparam logic [7:0] DAYS_29            = 8'h29;
    localparam logic [7:0] DAYS_30            = 8'h30;
    localparam logic [7:0] DAYS_31            = 8'h31;
    localparam logic [7:0] MONTH_FEB          = 8'h02;
    localparam logic [7:0] MONTH_APR          = 8'h04;
    localparam logic [7:0] MONTH_JUN          = 8'h06;
    localparam logic [7:0] MONTH_SEP          = 8'h09;
    localparam logic [7:0] MONTH_NOV          = 8'h11;

    // alarm entries: 0 seconds, 1 minutes, 2 hours
    localparam int unsigned ALARM_ENTRIES     = 3;

endpackage : bcca_pkg

// ---- rtl/bcca_top.sv ----
// bcd calendar counter chain with time-of-day alarm compare and register port
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - divider phase reads as 8 bits; bits 6..0 are the 1 Hz..64 Hz taps
// RULE_02 - counter reset or thirty-second adjust written one clears divider phase
// RULE_03 - divider phase keeps its value through srst
// RULE_04 - top bit of divider phase always reads zero
// RULE_05 - seconds count bcd 00..59, advances on each one-second divider carry
// RULE_06 - minutes count bcd 00..59, advances on seconds carry
// RULE_07 - hours count bcd 00..23, advances on minutes carry
// RULE_08 - weekday count 0..6 in bits 2..0, advances on day carry
// RULE_09 - weekday code 0 is sunday through 6 saturday
// RULE_10 - date count bcd 01..31, limit set by month and leap year
// RULE_11 - month count bcd, tens in bit 4, advances on date carry
// RULE_12 - year count bcd 00..99 in all eight bits, advances on month carry
// RULE_13 - year divisible by four is a leap year, february gets 29 days
// RULE_14 - software stops counting or uses carry retry before writing counters
// RULE_15 - software loads only in-range values into counters and alarms
// RULE_16 - calendar counters are never initialised by any reset
// RULE_17 - alarm bit 7 enables comparison of its counter
// RULE_18 - alarm fires only when all enabled alarms equal their counters
// RULE_19 - reset clears only the enable bits of the alarm registers
// RULE_20 - software programs alarm values in range, in bcd
// RULE_21 - carry flag sets whenever divider phase or seconds counts up
// RULE_22 - alarm flag sets on match, write zero clears, write one keeps
// RULE_23 - counters wrap to their lowest legal value and carry onward
module bcca_top
    import bcca_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = PHASE_TICK_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            alarm_match
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    localparam int unsigned PW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("bcca_top: TICK_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // one bcd step: returns {carry, next}; wraps from max to min
    function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                            input logic [7:0] vmax,
                                            input logic [7:0] vmin);
        logic [3:0] tens;
        logic [3:0] units;
        tens  = v[7:4];
        units = v[3:0];
        if (v == vmax) begin
            bcd_step = {1'b1, vmin};
        end else if (units == 4'h9) begin
            bcd_step = {1'b0, tens + 4'h1, 4'h0};
        end else begin
            bcd_step = {1'b0, tens, units + 4'h1};
        end
    endfunction

    // bcd year divisible by four: even tens need 0/4/8, odd tens need 2/6
    function automatic logic is_leap(input logic [7:0] y);
        logic [3:0] units;
        units = y[3:0];
        if (y[4]) begin
            is_leap = (units == 4'h2) || (units == 4'h6);
        end else begin
            is_leap = (units == 4'h0) || (units == 4'h4) || (units == 4'h8);
        end
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [PW-1:0] presc_count;
    logic [6:0]    phase;
    logic [7:0]    seconds_count;
    logic [7:0]    minutes_count;
    logic [7:0]    hours_count;
    logic [2:0]    weekday_count;
    logic [7:0]    date_count;
    logic [7:0]    month_count;
    logic [7:0]    year_count;
    logic [6:0]    alarm_value  [ALARM_ENTRIES];
    logic          alarm_enable [ALARM_ENTRIES];
    logic          run;
    logic          carry_flag;
    logic          alarm_match_flag;

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    logic       wr_phase_ctl;
    logic       wr_ctl1;
    logic       counter_reset_req;
    logic       adjust_req;
    logic [7:0] alarm_ofs [ALARM_ENTRIES];

    assign wr_phase_ctl      = reg_wr && (reg_addr == OFS_CONTROL_SECOND);
    assign wr_ctl1           = reg_wr && (reg_addr == OFS_CONTROL_FIRST);
    assign counter_reset_req = wr_phase_ctl && reg_wdata[COUNTER_RESET_BIT];
    assign adjust_req        = wr_phase_ctl && reg_wdata[ADJUST_BIT];
    assign alarm_ofs[0]      = OFS_SECONDS_ALARM;
    assign alarm_ofs[1]      = OFS_MINUTES_ALARM;
    assign alarm_ofs[2]      = OFS_HOURS_ALARM;

    // ------------------------------------------------------------------
    // prescaler from the system clock to the phase step
    // ------------------------------------------------------------------
    logic presc_wrap;
    logic phase_tick;

    assign presc_wrap = (presc_count == PW'(TICK_CYCLES - 1));
    assign phase_tick = run && presc_wrap && !counter_reset_req && !adjust_req;

    // the prescaler restarts with the phase so the first 128 Hz step is whole
    always_ff @(posedge sys_clk) begin
        if (srst || counter_reset_req || adjust_req || !run) begin
            presc_count <= '0;
        end else if (presc_wrap) begin
            presc_count <= '0;
        end else begin
            presc_count <= presc_count + PW'(1);
        end
    end

    // ------------------------------------------------------------------
    // counting chain, combinational next values
    // ------------------------------------------------------------------
    logic       sec_tick;
    logic       min_tick;
    logic       hour_tick;
    logic       day_tick;
    logic       month_tick;
    logic       year_tick;
    logic [8:0] sec_step;
    logic [8:0] min_step;
    logic [8:0] hour_step;
    logic [8:0] date_step;
    logic [8:0] month_step;
    logic [8:0] year_step;
    logic [7:0] date_max;

    // RULE_01 one-second carry from the top tap
    assign sec_tick   = phase_tick && (phase == 7'h7F);
    // RULE_23 each stage wraps and carries onward
    assign sec_step   = bcd_step(seconds_count, SIXTY_MAX, BCD_ZERO);
    assign min_step   = bcd_step(minutes_count, SIXTY_MAX, BCD_ZERO);
    assign hour_step  = bcd_step(hours_count, HOURS_MAX, BCD_ZERO);
    assign date_step  = bcd_step(date_count, date_max, DATE_MIN);
    assign month_step = bcd_step(month_count, MONTH_MAX, MONTH_MIN);
    assign year_step  = bcd_step(year_count, YEAR_MAX, BCD_ZERO);

    // thirty-second adjust rounds to the nearest minute and may carry
    assign min_tick   = adjust_req ? (seconds_count >= ADJUST_ROUND_UP)
                                   : (sec_tick && sec_step[8]);
    assign hour_tick  = min_tick && min_step[8];
    assign day_tick   = hour_tick && hour_step[8];
    assign month_tick = day_tick && date_step[8];
    assign year_tick  = month_tick && month_step[8];

    // RULE_10 month length; RULE_13 leap february
    always_comb begin
        date_max = DAYS_31;
        if (month_count == MONTH_FEB) begin
            date_max = is_leap(year_count) ? DAYS_29 : DAYS_28;
        end else if ((month_count == MONTH_APR) || (month_count == MONTH_JUN) ||
                     (month_count == MONTH_SEP) || (month_count == MONTH_NOV)) begin
            date_max = DAYS_30;
        end
    end

    // ------------------------------------------------------------------
    // divider phase counter, no reset on purpose
    // ------------------------------------------------------------------
    // RULE_03 srst is deliberately absent; RULE_02 cleared by software only
    always_ff @(posedge sys_clk) begin
        if (counter_reset_req || adjust_req) begin
            phase <= 7'h00;
        end else if (phase_tick) begin
            phase <= phase + 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // calendar counters; a write in the same cycle wins over a count
    // ------------------------------------------------------------------
    // RULE_16 no reset term in any counter; RULE_05 seconds
    always_ff @(posedge sys_clk) begin
        if (reg_wr && (reg_addr == OFS_SECONDS_COUNT)) begin
            seconds_count <= reg_wdata & MASK_SECONDS;
        end else if (adjust_req) begin
            seconds_count <= BCD_ZERO;
        end else if (sec_tick) begin
            seconds_count <= sec_step[7:0];
        end
    end

    // RULE_06 minutes
    always_ff @(posedge sys_clk) begin
        if (reg_wr && (reg_addr == OFS_MINUTES_COUNT)) begin
            minutes_count <= reg_wdata & MASK_MINUTES;
        end else if (min_tick) begin
            minutes_count <= min_step[7:0];
        end
    end

    // RULE_07 hours, 24-hour
    always_ff @(posedge sys_clk) begin
        if (reg_wr && (reg_addr == OFS_HOURS_COUNT)) begin
            hours_count <= reg_wdata & MASK_HOURS;
        end else if (hour_tick) begin
            hours_count <= hour_step[7:0];
        end
    end

    // RULE_08 weekday; RULE_09 sunday 0 rises to saturday 6
    always_ff @(posedge sys_clk) begin
        if (reg_wr && (reg_addr == OFS_WEEKDAY_COUNT)) begin
            weekday_count <= reg_wdata[2:0] & MASK_WEEKDAY[2:0];
        end else if (day_tick) begin
            weekday_count <= (weekday_count == WEEKDAY_MAX[2:0]) ? 3'h0
                                                                 : weekday_count + 3'h1;
        end
    end

    // RULE_10 date
    always_ff @(posedge sys_clk) begin
        if (reg_wr && (reg_addr == OFS_DATE_COUNT)) begin
            date_count <= reg_wdata & MASK_DATE;
        end else if (day_tick) begin
            date_count <= date_step[7:0];
        end
    end

    // RULE_11 month
    always_ff @(posedge sys_clk) begin
        if (reg_wr && (reg_addr == OFS_MONTH_COUNT)) begin
            month_count <= reg_wdata & MASK_MONTH;
        end else if (month_tick) begin
            month_count <= month_step[7:0];
        end
    end

    // RULE_12 two-digit year
    always_ff @(posedge sys_clk) begin
        if (reg_wr && (reg_addr == OFS_YEAR_COUNT)) begin
            year_count <= reg_wdata & MASK_YEAR;
        end else if (year_tick) begin
            year_count <= year_step[7:0];
        end
    end

    // ------------------------------------------------------------------
    // alarm entries and compare
    // ------------------------------------------------------------------
    logic [6:0] alarm_cnt  [ALARM_ENTRIES];
    logic [6:0] alarm_mask [ALARM_ENTRIES];
    logic       entry_ok   [ALARM_ENTRIES];
    logic       entry_on   [ALARM_ENTRIES];
    logic       alarm_hit;

    assign alarm_cnt[0]  = seconds_count[6:0];
    assign alarm_cnt[1]  = minutes_count[6:0];
    assign alarm_cnt[2]  = hours_count[6:0];
    assign alarm_mask[0] = MASK_SECONDS[6:0];
    assign alarm_mask[1] = MASK_MINUTES[6:0];
    assign alarm_mask[2] = MASK_HOURS[6:0];

    for (genvar gi = 0; gi < ALARM_ENTRIES; gi++) begin : g_alarm
        logic alarm_wr;
        assign alarm_wr = reg_wr && (reg_addr == alarm_ofs[gi]);

        // RULE_19 only the enable bit sees reset
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                alarm_enable[gi] <= ENABLE_RESET;
            end else if (alarm_wr) begin
                alarm_enable[gi] <= reg_wdata[ENABLE_BIT];
            end
        end

        // value field keeps its contents through reset
        always_ff @(posedge sys_clk) begin
            if (alarm_wr) begin
                alarm_value[gi] <= reg_wdata[6:0] & alarm_mask[gi];
            end
        end

        // RULE_17 a disabled entry drops out of the compare
        assign entry_on[gi] = alarm_enable[gi];
        assign entry_ok[gi] = !alarm_enable[gi] || (alarm_value[gi] == alarm_cnt[gi]);
    end

    // RULE_18 all enabled entries equal at once, at least one enabled
    always_comb begin
        logic all_ok;
        logic any_on;
        all_ok = 1'b1;
        any_on = 1'b0;
        for (int i = 0; i < ALARM_ENTRIES; i++) begin
            all_ok = all_ok && entry_ok[i];
            any_on = any_on || entry_on[i];
        end
        alarm_hit = all_ok && any_on;
    end

    // registered copy of the compare for the outside
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alarm_match <= 1'b0;
        end else begin
            alarm_match <= alarm_hit;
        end
    end

    // ------------------------------------------------------------------
    // control and status bits
    // ------------------------------------------------------------------
    // run control; counter reset and adjust are one-shot commands
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            run <= RUN_RESET;
        end else if (wr_phase_ctl) begin
            run <= reg_wdata[RUN_BIT];
        end
    end

    // RULE_21 carry flag; a count in the clearing cycle still sets it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            carry_flag <= 1'b0;
        end else if (phase_tick || (wr_ctl1 && reg_wdata[CARRY_FLAG_BIT])) begin
            carry_flag <= 1'b1;
        end else if (wr_ctl1) begin
            carry_flag <= 1'b0;
        end
    end

    // RULE_22 alarm flag; match wins over a clearing write
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alarm_match_flag <= 1'b0;
        end else if (alarm_hit) begin
            alarm_match_flag <= 1'b1;
        end else if (wr_ctl1 && !reg_wdata[ALARM_FLAG_BIT]) begin
            alarm_match_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read path: data valid in the cycle after the strobe only
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                // RULE_04 top bit forced to zero
                OFS_DIVIDER_PHASE:  next_rdata = {1'b0, phase};
                OFS_SECONDS_COUNT:  next_rdata = seconds_count;
                OFS_MINUTES_COUNT:  next_rdata = minutes_count;
                OFS_HOURS_COUNT:    next_rdata = hours_count;
                OFS_WEEKDAY_COUNT:  next_rdata = {5'h00, weekday_count};
                OFS_DATE_COUNT:     next_rdata = date_count;
                OFS_MONTH_COUNT:    next_rdata = month_count;
                OFS_YEAR_COUNT:     next_rdata = year_count;
                OFS_SECONDS_ALARM:  next_rdata = {alarm_enable[0], alarm_value[0]};
                OFS_MINUTES_ALARM:  next_rdata = {alarm_enable[1], alarm_value[1]};
                OFS_HOURS_ALARM:    next_rdata = {alarm_enable[2], alarm_value[2]};
                OFS_CONTROL_FIRST: begin
                    next_rdata[CARRY_FLAG_BIT] = carry_flag;
                    next_rdata[ALARM_FLAG_BIT] = alarm_match_flag;
                end
                OFS_CONTROL_SECOND: next_rdata[RUN_BIT] = run;
                default:            next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // bcca_top

// ---- verif/bcca_chk.sv ----
// port-level assertions for the bcd calendar counters and alarm compare
`timescale 1ns/10ps
module bcca_chk
    import bcca_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = PHASE_TICK_CYCLES
) (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       alarm_match
);
    // ------------------------------------------------------------------
    // read data of each counter stays inside its legal field
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    phase_top_a : assert property (reg_rd && reg_addr == OFS_DIVIDER_PHASE |=> !reg_rdata[7])
        else $error("divider phase top bit read as one");
    sec_range_a : assert property (reg_rd && reg_addr == OFS_SECONDS_COUNT |=>
        reg_rdata <= SIXTY_MAX && reg_rdata[3:0] <= 4'h9) else $error("seconds out of range");
    min_range_a : assert property (reg_rd && reg_addr == OFS_MINUTES_COUNT |=>
        reg_rdata <= SIXTY_MAX && reg_rdata[3:0] <= 4'h9) else $error("minutes out of range");
    hour_range_a : assert property (reg_rd && reg_addr == OFS_HOURS_COUNT |=>
        reg_rdata <= HOURS_MAX && reg_rdata[3:0] <= 4'h9) else $error("hours out of range");
    wday_range_a : assert property (reg_rd && reg_addr == OFS_WEEKDAY_COUNT |=>
        reg_rdata <= WEEKDAY_MAX) else $error("weekday out of range");
    date_range_a : assert property (reg_rd && reg_addr == OFS_DATE_COUNT |=>
        reg_rdata inside {[DATE_MIN:DAYS_31]}) else $error("date out of range");
    month_range_a : assert property (reg_rd && reg_addr == OFS_MONTH_COUNT |=>
        reg_rdata <= MONTH_MAX) else $error("month out of range");
    year_digit_a : assert property (reg_rd && reg_addr == OFS_YEAR_COUNT |=>
        reg_rdata[7:4] <= 4'h9 && reg_rdata[3:0] <= 4'h9) else $error("year not bcd");
    // enables are cleared by reset, so no compare can hold right after it
    match_reset_a : assert property ($fell(srst) |-> !alarm_match)
        else $error("alarm match right after reset");
endmodule // bcca_chk

bind bcca_top bcca_chk #(.TICK_CYCLES(TICK_CYCLES)) u_bcca_chk (.sys_clk(sys_clk),
    .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_match(alarm_match));

// ---- verif/tb_top.sv ----
// self-checking bench for the bcd calendar counters and alarm compare
`timescale 1ns/10ps
module tb_top
    import bcca_pkg::*;
;
    // ------------------------------------------------------------------
    // stimulus state and design
    // ------------------------------------------------------------------
    logic       sys_clk   = 1'b0;
    logic       srst      = 1'b1;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic       alarm_match;
    logic [7:0] p;
    logic [7:0] q;
    int         error_cnt = 0;
    int         cmp_count = 0;
    int         cyc       = 0;
    // weekday, date, month and year counters
    localparam logic [7:0] CAL [4] = '{OFS_WEEKDAY_COUNT, OFS_DATE_COUNT,
                                       OFS_MONTH_COUNT, OFS_YEAR_COUNT};
    // day-end cases at 23:59:59: four start values, then four expected values
    localparam logic [7:0] DCASE [4][8] = '{
        '{8'h06, 8'h28, 8'h02, 8'h23, 8'h00, 8'h01, 8'h03, 8'h23},
        '{8'h06, 8'h28, 8'h02, 8'h24, 8'h00, 8'h29, 8'h02, 8'h24},
        '{8'h02, 8'h30, 8'h04, 8'h23, 8'h03, 8'h01, 8'h05, 8'h23},
        '{8'h05, 8'h31, 8'h12, 8'h99, 8'h06, 8'h01, 8'h01, 8'h00}};
    // a short tick keeps one second at 512 cycles
    bcca_top #(.TICK_CYCLES(4)) u_bcca_top (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .alarm_match(alarm_match));
    initial forever #20 sys_clk = ~sys_clk;
    // ------------------------------------------------------------------
    // register port tasks; a strobe-low edge always passes between accesses
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] d;
        rd(a, d);
        cmp(d & m, exp);
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard: the whole sequence needs under 4000 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            error_cnt++;
            finish_test();
        end
    end
    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        wr(OFS_CONTROL_SECOND, 8'h02);
        wr(OFS_DIVIDER_PHASE, 8'h55);
        chk(OFS_DIVIDER_PHASE, 8'h00, 8'hFF);
        chk(OFS_CONTROL_FIRST, 8'h00, 8'h01);
        chk(8'h16, 8'h00, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            chk(OFS_SECONDS_ALARM + 8'(2 * i), 8'h00, 8'h80);
        end
        $display("reset state test done");
        // run one second across each day end, then stop and read back
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CONTROL_FIRST, 8'h00);
            wr(OFS_SECONDS_COUNT, SIXTY_MAX);
            wr(OFS_MINUTES_COUNT, SIXTY_MAX);
            wr(OFS_HOURS_COUNT, HOURS_MAX);
            for (int j = 0; j < 4; j++) begin
                wr(CAL[j], DCASE[k][j]);
            end
            wr(OFS_CONTROL_SECOND, 8'h0A);
            repeat (520) @(posedge sys_clk);
            wr(OFS_CONTROL_SECOND, 8'h00);
            chk(OFS_SECONDS_COUNT, 8'h00, 8'hFF);
            chk(OFS_MINUTES_COUNT, 8'h00, 8'hFF);
            chk(OFS_HOURS_COUNT, 8'h00, 8'hFF);
            for (int j = 0; j < 4; j++) begin
                chk(CAL[j], DCASE[k][j + 4], 8'hFF);
            end
            chk(OFS_CONTROL_FIRST, 8'h80, 8'h80);
            $display("day end test %0d done", k);
        end
        // phase mid-count and the date count survive a second reset
        wr(OFS_CONTROL_SECOND, 8'h0A);
        repeat (400) @(posedge sys_clk);
        wr(OFS_CONTROL_SECOND, 8'h00);
        rd(OFS_DIVIDER_PHASE, p);
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        wr(OFS_CONTROL_SECOND, 8'h00);
        rd(OFS_DIVIDER_PHASE, q);
        cmp(q, p);
        chk(OFS_DATE_COUNT, 8'h01, 8'hFF);
        $display("retention test done");
        // thirty-second adjust rounds up into the minute
        wr(OFS_SECONDS_COUNT, 8'h45);
        wr(OFS_MINUTES_COUNT, 8'h10);
        wr(OFS_CONTROL_SECOND, 8'h04);
        chk(OFS_SECONDS_COUNT, 8'h00, 8'hFF);
        chk(OFS_MINUTES_COUNT, 8'h11, 8'hFF);
        chk(OFS_DIVIDER_PHASE, 8'h00, 8'hFF);
        $display("adjust test done");
        // alarm: hour disabled, then enabled wrong, then enabled right
        wr(OFS_SECONDS_COUNT, 8'h56);
        wr(OFS_MINUTES_COUNT, 8'h34);
        wr(OFS_HOURS_COUNT, 8'h12);
        wr(OFS_CONTROL_FIRST, 8'h00);
        wr(OFS_SECONDS_ALARM, 8'hD6);
        wr(OFS_MINUTES_ALARM, 8'hB4);
        wr(OFS_HOURS_ALARM, 8'h13);
        repeat (2) @(posedge sys_clk);
        #1;
        cmp({7'h00, alarm_match}, 8'h01);
        wr(OFS_HOURS_ALARM, 8'h93);
        wr(OFS_CONTROL_FIRST, 8'h01);
        chk(OFS_CONTROL_FIRST, 8'h01, 8'h81);
        wr(OFS_CONTROL_FIRST, 8'h00);
        chk(OFS_CONTROL_FIRST, 8'h00, 8'h81);
        cmp({7'h00, alarm_match}, 8'h00);
        wr(OFS_HOURS_ALARM, 8'h92);
        repeat (2) @(posedge sys_clk);
        #1;
        cmp({7'h00, alarm_match}, 8'h01);
        $display("alarm test done");
        finish_test();
    end
endmodule // tb_top
